/* core/etm_pkg.sv */
// package with constants and carrier types for the enclave tweak modifier csr file
package etm_pkg;

    // ----------------------------------------------------------------
    // privilege encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;

    // ----------------------------------------------------------------
    // default csr numbers, overridable at integration
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_M_LOAD_LO = 12'h7c0;
    localparam logic [11:0] ADDR_M_STORE_LO = 12'h7c1;
    localparam logic [11:0] ADDR_M_FETCH_LO = 12'h7c2;
    localparam logic [11:0] ADDR_M_LOAD_HI = 12'h7c3;
    localparam logic [11:0] ADDR_M_STORE_HI = 12'h7c4;
    localparam logic [11:0] ADDR_M_FETCH_HI = 12'h7c5;
    localparam logic [11:0] ADDR_S_LOAD_LO = 12'h5c0;
    localparam logic [11:0] ADDR_S_STORE_LO = 12'h5c1;
    localparam logic [11:0] ADDR_S_FETCH_LO = 12'h5c2;
    localparam logic [11:0] ADDR_S_LOAD_HI = 12'h5c3;
    localparam logic [11:0] ADDR_S_STORE_HI = 12'h5c4;
    localparam logic [11:0] ADDR_S_FETCH_HI = 12'h5c5;
    localparam logic [11:0] ADDR_U_LOAD_LO = 12'h8c0;
    localparam logic [11:0] ADDR_U_STORE_LO = 12'h8c1;
    localparam logic [11:0] ADDR_U_FETCH_LO = 12'h8c2;
    localparam logic [11:0] ADDR_U_LOAD_HI = 12'h8c3;
    localparam logic [11:0] ADDR_U_STORE_HI = 12'h8c4;
    localparam logic [11:0] ADDR_U_FETCH_HI = 12'h8c5;

    // ----------------------------------------------------------------
    // reset values and widths
    // ----------------------------------------------------------------
    localparam logic [31:0] TWEAK_WORD_RESET = 32'h0000_0000;
    localparam logic [63:0] TWEAK_RESET = 64'h0;

    // csr request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } etm_csr_req_t;

    // answer to the core
    typedef struct packed {
        logic hit;
        logic illegal;
        logic flush;
        logic [31:0] rdata;
    } etm_csr_rsp_t;

    // one register set: fetch, load, store modifiers
    typedef struct packed {
        logic [63:0] fetch;
        logic [63:0] load;
        logic [63:0] store;
    } etm_mod_set_t;

endpackage : etm_pkg

/* core/etm_csr_file.sv */
// enclave tweak modifier csr file with tweak generation for the caches
`timescale 1ns/10ps
`default_nettype none
module etm_csr_file #(
    parameter bit isolation_present_param = 1'b1,
    parameter logic [11:0] addr_m_load_lo = etm_pkg::ADDR_M_LOAD_LO,
    parameter logic [11:0] addr_m_store_lo = etm_pkg::ADDR_M_STORE_LO,
    parameter logic [11:0] addr_m_fetch_lo = etm_pkg::ADDR_M_FETCH_LO,
    parameter logic [11:0] addr_m_load_hi = etm_pkg::ADDR_M_LOAD_HI,
    parameter logic [11:0] addr_m_store_hi = etm_pkg::ADDR_M_STORE_HI,
    parameter logic [11:0] addr_m_fetch_hi = etm_pkg::ADDR_M_FETCH_HI,
    parameter logic [11:0] addr_s_load_lo = etm_pkg::ADDR_S_LOAD_LO,
    parameter logic [11:0] addr_s_store_lo = etm_pkg::ADDR_S_STORE_LO,
    parameter logic [11:0] addr_s_fetch_lo = etm_pkg::ADDR_S_FETCH_LO,
    parameter logic [11:0] addr_s_load_hi = etm_pkg::ADDR_S_LOAD_HI,
    parameter logic [11:0] addr_s_store_hi = etm_pkg::ADDR_S_STORE_HI,
    parameter logic [11:0] addr_s_fetch_hi = etm_pkg::ADDR_S_FETCH_HI,
    parameter logic [11:0] addr_u_load_lo = etm_pkg::ADDR_U_LOAD_LO,
    parameter logic [11:0] addr_u_store_lo = etm_pkg::ADDR_U_STORE_LO,
    parameter logic [11:0] addr_u_fetch_lo = etm_pkg::ADDR_U_FETCH_LO,
    parameter logic [11:0] addr_u_load_hi = etm_pkg::ADDR_U_LOAD_HI,
    parameter logic [11:0] addr_u_store_hi = etm_pkg::ADDR_U_STORE_HI,
    parameter logic [11:0] addr_u_fetch_hi = etm_pkg::ADDR_U_FETCH_HI
) (
    input wire logic clock, // core clock
    input wire logic rst_n, // async reset, active low
    input wire etm_pkg::etm_csr_req_t csr_req, // csr access from the pipeline
    input wire logic [1:0] current_privilege, // current hart privilege
    input wire logic [1:0] effective_access_privilege, // load/store privilege after override
    input wire logic access_is_store, // direction from the load/store unit
    output etm_pkg::etm_csr_rsp_t csr_rsp_reg, // registered csr answer
    output logic [63:0] instr_cache_tweak_out, // tweak to instruction cache
    output logic [63:0] data_cache_tweak_out // tweak to data cache
);

    // ----------------------------------------------------------------
    // storage: machine set and one shared lower-mode set
    // ----------------------------------------------------------------
    etm_pkg::etm_mod_set_t mach_reg;
    etm_pkg::etm_mod_set_t low_reg;

    logic is_m;
    logic is_lowmode;
    logic [2:0] sel_kind; // one-hot: 1 fetch, 2 load, 4 store
    logic sel_hi;
    logic sel_mach;
    logic sel_lowname;
    logic sel_lowfetch;
    logic hit;
    logic illegal;
    logic do_write;
    logic [31:0] rdata;
    logic flush;
    logic [63:0] f_mod;
    logic [63:0] ld_mod;
    logic [63:0] st_mod;

    assign is_m = (current_privilege == etm_pkg::PRIV_MACHINE);
    assign is_lowmode = !is_m;

    // ----------------------------------------------------------------
    // address decode; supervisor and user names share one target
    // ----------------------------------------------------------------
    always_comb begin
        sel_kind = 3'h0;
        sel_hi = 1'b0;
        sel_mach = 1'b0;
        sel_lowname = 1'b0;
        hit = isolation_present_param;
        if (csr_req.addr == addr_m_fetch_lo) begin
            sel_mach = 1'b1;
            sel_kind = 3'h1;
        end else if (csr_req.addr == addr_m_fetch_hi) begin
            sel_mach = 1'b1;
            sel_kind = 3'h1;
            sel_hi = 1'b1;
        end else if (csr_req.addr == addr_m_load_lo) begin
            sel_mach = 1'b1;
            sel_kind = 3'h2;
        end else if (csr_req.addr == addr_m_load_hi) begin
            sel_mach = 1'b1;
            sel_kind = 3'h2;
            sel_hi = 1'b1;
        end else if (csr_req.addr == addr_m_store_lo) begin
            sel_mach = 1'b1;
            sel_kind = 3'h4;
        end else if (csr_req.addr == addr_m_store_hi) begin
            sel_mach = 1'b1;
            sel_kind = 3'h4;
            sel_hi = 1'b1;
        end else if (csr_req.addr == addr_u_fetch_lo || csr_req.addr == addr_s_fetch_lo) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h1;
        end else if (csr_req.addr == addr_u_fetch_hi || csr_req.addr == addr_s_fetch_hi) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h1;
            sel_hi = 1'b1;
        end else if (csr_req.addr == addr_u_load_lo || csr_req.addr == addr_s_load_lo) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h2;
        end else if (csr_req.addr == addr_u_load_hi || csr_req.addr == addr_s_load_hi) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h2;
            sel_hi = 1'b1;
        end else if (csr_req.addr == addr_u_store_lo || csr_req.addr == addr_s_store_lo) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h4;
        end else if (csr_req.addr == addr_u_store_hi || csr_req.addr == addr_s_store_hi) begin
            sel_lowname = 1'b1;
            sel_kind = 3'h4;
            sel_hi = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    assign sel_lowfetch = sel_lowname && sel_kind[0];

    // ----------------------------------------------------------------
    // access class check
    // ----------------------------------------------------------------
    always_comb begin
        illegal = 1'b0;
        if (csr_req.valid && hit) begin
            if (sel_mach && is_lowmode) begin
                illegal = 1'b1;
            end else if (sel_lowfetch && is_lowmode) begin
                illegal = 1'b1;
            end
        end
    end

    assign do_write = csr_req.valid && hit && csr_req.write && !illegal;

    // ----------------------------------------------------------------
    // read mux; lower modes see zero on the load/store words
    // ----------------------------------------------------------------
    always_comb begin
        etm_pkg::etm_mod_set_t src;
        logic [63:0] word64;
        src = sel_mach ? mach_reg : low_reg;
        word64 = sel_kind[0] ? src.fetch : (sel_kind[1] ? src.load : src.store);
        rdata = sel_hi ? word64[63:32] : word64[31:0];
        if (!hit || illegal || (sel_lowname && is_lowmode)) begin
            rdata = etm_pkg::TWEAK_WORD_RESET;
        end
    end

    // flush when the written set is the one the hart now uses, or for load/store words the one the effective access privilege uses
    always_comb begin
        flush = 1'b0;
        if (do_write) begin
            flush = sel_mach ? is_m : is_lowmode;
            if (sel_kind[1] || sel_kind[2]) begin
                flush = flush || (sel_mach ?
                    (effective_access_privilege == etm_pkg::PRIV_MACHINE) :
                    (effective_access_privilege != etm_pkg::PRIV_MACHINE));
            end
        end
    end

    // ----------------------------------------------------------------
    // modifier storage, one 32-bit half per write
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mach_reg <= {3{etm_pkg::TWEAK_RESET}};
            low_reg <= {3{etm_pkg::TWEAK_RESET}};
        end else if (do_write) begin
            if (sel_mach) begin
                if (sel_kind[0] && sel_hi) mach_reg.fetch[63:32] <= csr_req.wdata;
                if (sel_kind[0] && !sel_hi) mach_reg.fetch[31:0] <= csr_req.wdata;
                if (sel_kind[1] && sel_hi) mach_reg.load[63:32] <= csr_req.wdata;
                if (sel_kind[1] && !sel_hi) mach_reg.load[31:0] <= csr_req.wdata;
                if (sel_kind[2] && sel_hi) mach_reg.store[63:32] <= csr_req.wdata;
                if (sel_kind[2] && !sel_hi) mach_reg.store[31:0] <= csr_req.wdata;
            end else begin
                if (sel_kind[0] && sel_hi) low_reg.fetch[63:32] <= csr_req.wdata;
                if (sel_kind[0] && !sel_hi) low_reg.fetch[31:0] <= csr_req.wdata;
                if (sel_kind[1] && sel_hi) low_reg.load[63:32] <= csr_req.wdata;
                if (sel_kind[1] && !sel_hi) low_reg.load[31:0] <= csr_req.wdata;
                if (sel_kind[2] && sel_hi) low_reg.store[63:32] <= csr_req.wdata;
                if (sel_kind[2] && !sel_hi) low_reg.store[31:0] <= csr_req.wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered csr answer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csr_rsp_reg <= '0;
        end else begin
            csr_rsp_reg.hit <= csr_req.valid && hit;
            csr_rsp_reg.illegal <= illegal;
            csr_rsp_reg.flush <= flush;
            csr_rsp_reg.rdata <= (csr_req.valid && !csr_req.write) ? rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // tweak generation; the instruction tweak never follows the access override
    // ----------------------------------------------------------------
    assign f_mod = is_m ? mach_reg.fetch : low_reg.fetch;
    assign ld_mod = (effective_access_privilege == etm_pkg::PRIV_MACHINE) ?
        mach_reg.load : low_reg.load;
    assign st_mod = (effective_access_privilege == etm_pkg::PRIV_MACHINE) ?
        mach_reg.store : low_reg.store;

    // the data tweak uses the fetch modifier of the access privilege, so a
    // leaked load/store modifier alone cannot open another enclave
    logic [63:0] f_mod_ls;
    assign f_mod_ls = (effective_access_privilege == etm_pkg::PRIV_MACHINE) ?
        mach_reg.fetch : low_reg.fetch;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            instr_cache_tweak_out <= etm_pkg::TWEAK_RESET;
            data_cache_tweak_out <= etm_pkg::TWEAK_RESET;
        end else begin
            instr_cache_tweak_out <= f_mod;
            data_cache_tweak_out <= f_mod_ls ^ (access_is_store ? st_mod : ld_mod);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_mach_refuse;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && hit && sel_mach && is_lowmode) |=> csr_rsp_reg.illegal;
    endproperty
    a_mach_refuse: assert property (p_mach_refuse) else $error("machine csr not refused");

    property p_lowfetch_refuse;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && hit && sel_lowfetch && is_lowmode && csr_req.write)
            |=> csr_rsp_reg.illegal && $stable(low_reg.fetch);
    endproperty
    a_lowfetch_refuse: assert property (p_lowfetch_refuse)
        else $error("lower fetch write taken");

    property p_low_write;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && csr_req.write && csr_req.addr == addr_u_load_lo && is_lowmode && hit)
            |=> low_reg.load[31:0] == $past(csr_req.wdata);
    endproperty
    a_low_write: assert property (p_low_write) else $error("user load write lost");

    property p_low_read_zero;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && !csr_req.write && sel_lowname && is_lowmode)
            |=> csr_rsp_reg.rdata == 32'h0000_0000;
    endproperty
    a_low_read_zero: assert property (p_low_read_zero) else $error("lower read leaked");

    property p_alias;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && csr_req.write && csr_req.addr == addr_s_store_hi && is_m && hit)
            |=> low_reg.store[63:32] == $past(csr_req.wdata);
    endproperty
    a_alias: assert property (p_alias) else $error("alias write missed");

    property p_itweak;
        @(posedge clock) disable iff (!rst_n)
        ##1 instr_cache_tweak_out == ($past(is_m) ? $past(mach_reg.fetch) : $past(low_reg.fetch));
    endproperty
    a_itweak: assert property (p_itweak) else $error("fetch tweak wrong");

    property p_dtweak;
        @(posedge clock) disable iff (!rst_n)
        (effective_access_privilege == etm_pkg::PRIV_MACHINE && !access_is_store)
            |=> data_cache_tweak_out == ($past(mach_reg.fetch) ^ $past(mach_reg.load));
    endproperty
    a_dtweak: assert property (p_dtweak) else $error("data tweak wrong");

    property p_flush;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && csr_req.write && hit && sel_mach && is_m) |=> csr_rsp_reg.flush;
    endproperty
    a_flush: assert property (p_flush) else $error("flush missing");

    property p_mach_hi_write;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && csr_req.write && hit && csr_req.addr == addr_m_fetch_hi && is_m)
            |=> mach_reg.fetch[63:32] == $past(csr_req.wdata);
    endproperty
    a_mach_hi_write: assert property (p_mach_hi_write) else $error("high word lost");

    property p_miss_quiet;
        @(posedge clock) disable iff (!rst_n)
        (csr_req.valid && !hit)
            |=> !csr_rsp_reg.hit && !csr_rsp_reg.illegal && csr_rsp_reg.rdata == 32'h0000_0000;
    endproperty
    a_miss_quiet: assert property (p_miss_quiet) else $error("unmapped access answered");

    c_mach_write: cover property (@(posedge clock) do_write && sel_mach);
    c_user_write: cover property (@(posedge clock)
        do_write && current_privilege == etm_pkg::PRIV_USER);
    c_refused: cover property (@(posedge clock) illegal);
    c_override: cover property (@(posedge clock)
        !is_m && effective_access_privilege == etm_pkg::PRIV_MACHINE);
    c_miss: cover property (@(posedge clock) csr_req.valid && !hit);

endmodule : etm_csr_file
`default_nettype wire

/* tb/etm_core_model.sv */
// core-side model: csr requests, privilege modes and load/store direction
`timescale 1ns/10ps
`default_nettype none
module etm_core_model (
    input wire logic clock, // core clock
    output etm_pkg::etm_csr_req_t csr_req, // csr access to the file
    output logic [1:0] current_privilege, // hart mode
    output logic [1:0] effective_access_privilege, // load/store mode after override
    output logic access_is_store, // load/store direction
    input wire etm_pkg::etm_csr_rsp_t csr_rsp_reg // registered answer
);
    initial begin
        csr_req = '0;
        current_privilege = etm_pkg::PRIV_MACHINE;
        effective_access_privilege = etm_pkg::PRIV_MACHINE;
        access_is_store = 1'h0;
    end

    // -----------------------------------------------------------
    // request tasks, always entered at a falling edge
    // -----------------------------------------------------------
    // valid stays up on return so that requests can run back to back
    task automatic access(input logic [1:0] prv, input logic [1:0] eff, input logic wr,
                          input logic [11:0] addr, input logic [31:0] wd,
                          output etm_pkg::etm_csr_rsp_t rsp);
        current_privilege = prv;
        effective_access_privilege = eff;
        csr_req = {1'h1, wr, addr, wd};
        @(posedge clock);
        @(negedge clock);
        rsp = csr_rsp_reg;
    endtask : access

    // released data lines are scrambled so a stale value never looks valid
    task automatic idle(input int n);
        csr_req.valid = 1'h0;
        csr_req.wdata = ~csr_req.wdata;
        repeat (n) begin
            @(posedge clock);
            @(negedge clock);
        end
    endtask : idle

    task automatic mode(input logic [1:0] prv, input logic [1:0] eff, input logic st);
        current_privilege = prv;
        effective_access_privilege = eff;
        access_is_store = st;
    endtask : mode
endmodule : etm_core_model
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the enclave tweak modifier csr file
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [1:0] prv;
        logic [1:0] eff;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wd;
        logic ill;
        logic fl;
        logic [31:0] rd;
    } etm_row_t;

    localparam logic [1:0] M = etm_pkg::PRIV_MACHINE;
    localparam logic [1:0] S = etm_pkg::PRIV_SUPER;
    localparam logic [1:0] U = etm_pkg::PRIV_USER;
    // machine load high word moved off its default number at integration
    localparam logic [11:0] MLH = 12'h7d3;

    logic clock = 1'h0;
    logic rst_n = 1'h0;
    etm_pkg::etm_csr_req_t csr_req;
    etm_pkg::etm_csr_rsp_t rsp_reg;
    etm_pkg::etm_csr_rsp_t rsp;
    etm_pkg::etm_csr_rsp_t off_rsp_reg;
    logic [1:0] cur_prv;
    logic [1:0] eff_prv;
    logic is_store;
    logic [63:0] itw;
    logic [63:0] dtw;
    logic [31:0] sh [12];
    etm_row_t rows [$];
    int error_cnt = 0;
    int total_checks = 0;

    always #2 clock = ~clock;

    etm_csr_file #(.addr_m_load_hi(MLH)) uut (
        .clock(clock), .rst_n(rst_n), .csr_req(csr_req), .current_privilege(cur_prv),
        .effective_access_privilege(eff_prv), .access_is_store(is_store),
        .csr_rsp_reg(rsp_reg), .instr_cache_tweak_out(itw), .data_cache_tweak_out(dtw));

    // extension left out at build time: nothing may answer
    etm_csr_file #(.isolation_present_param(1'b0)) uut_off (
        .clock(clock), .rst_n(rst_n), .csr_req(csr_req), .current_privilege(cur_prv),
        .effective_access_privilege(eff_prv), .access_is_store(is_store),
        .csr_rsp_reg(off_rsp_reg), .instr_cache_tweak_out(), .data_cache_tweak_out());

    etm_core_model core (
        .clock(clock), .csr_req(csr_req), .current_privilege(cur_prv),
        .effective_access_privilege(eff_prv), .access_is_store(is_store),
        .csr_rsp_reg(rsp_reg));

    // -----------------------------------------------------------
    // checking and closing
    // -----------------------------------------------------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic add(input logic [1:0] p, input logic [1:0] e, input logic w,
                       input logic [11:0] a, input logic [31:0] d, input logic i,
                       input logic f, input logic [31:0] r);
        rows.push_back('{p, e, w, a, d, i, f, r});
    endtask : add

    // shadow layout per set: load_lo, store_lo, fetch_lo, load_hi, store_hi, fetch_hi
    function automatic int sidx(input logic [11:0] a);
        return ((a[11:8] == 4'h7) ? 0 : 6) + int'(a[2:0]);
    endfunction : sidx

    function automatic logic [63:0] mod64(input int set, input int k);
        return {sh[set + k + 3], sh[set + k]};
    endfunction : mod64

    task automatic tweaks(input logic [1:0] prv, input logic [1:0] eff, input logic st);
        int fs;
        int ls;
        fs = (prv == M) ? 0 : 6;
        ls = (eff == M) ? 0 : 6;
        core.mode(prv, eff, st);
        core.idle(2);
        check("instr_tweak", itw, mod64(fs, 2));
        check("data_tweak", dtw, mod64(ls, 2) ^ mod64(ls, st ? 1 : 0));
    endtask : tweaks

    initial begin
        #2000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        foreach (sh[i]) sh[i] = 32'h0;
        add(M, M, 1'h1, etm_pkg::ADDR_M_LOAD_LO, 32'h1111_1111, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h1, MLH, 32'h2222_2222, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h1, etm_pkg::ADDR_M_STORE_LO, 32'h3333_3333, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h1, etm_pkg::ADDR_M_STORE_HI, 32'h4444_4444, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h1, etm_pkg::ADDR_M_FETCH_LO, 32'ha5a5_a5a5, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h1, etm_pkg::ADDR_M_FETCH_HI, 32'h5a5a_5a5a, 1'h0, 1'h1, 32'h0);
        add(M, M, 1'h0, etm_pkg::ADDR_M_FETCH_HI, 32'h0, 1'h0, 1'h0, 32'h5a5a_5a5a);
        add(M, M, 1'h0, MLH, 32'h0, 1'h0, 1'h0, 32'h2222_2222);
        add(M, M, 1'h1, etm_pkg::ADDR_U_FETCH_LO, 32'h0f0f_0f0f, 1'h0, 1'h0, 32'h0);
        add(M, M, 1'h1, etm_pkg::ADDR_S_FETCH_HI, 32'hf0f0_f0f0, 1'h0, 1'h0, 32'h0);
        add(M, M, 1'h0, etm_pkg::ADDR_U_FETCH_HI, 32'h0, 1'h0, 1'h0, 32'hf0f0_f0f0);
        add(U, U, 1'h1, etm_pkg::ADDR_U_LOAD_LO, 32'h1234_5678, 1'h0, 1'h1, 32'h0);
        add(S, S, 1'h1, etm_pkg::ADDR_S_STORE_HI, 32'h9abc_def0, 1'h0, 1'h1, 32'h0);
        add(M, U, 1'h1, etm_pkg::ADDR_U_LOAD_HI, 32'h0000_00ff, 1'h0, 1'h1, 32'h0);
        add(U, U, 1'h0, etm_pkg::ADDR_U_LOAD_LO, 32'h0, 1'h0, 1'h0, 32'h0);
        add(S, S, 1'h0, etm_pkg::ADDR_S_STORE_HI, 32'h0, 1'h0, 1'h0, 32'h0);
        add(M, M, 1'h0, etm_pkg::ADDR_S_LOAD_LO, 32'h0, 1'h0, 1'h0, 32'h1234_5678);
        add(M, M, 1'h0, etm_pkg::ADDR_U_STORE_HI, 32'h0, 1'h0, 1'h0, 32'h9abc_def0);
        add(U, U, 1'h1, etm_pkg::ADDR_M_LOAD_LO, 32'hdead_beef, 1'h1, 1'h0, 32'h0);
        add(S, S, 1'h0, etm_pkg::ADDR_M_FETCH_LO, 32'h0, 1'h1, 1'h0, 32'h0);
        add(U, U, 1'h1, etm_pkg::ADDR_U_FETCH_LO, 32'hdead_beef, 1'h1, 1'h0, 32'h0);
        add(S, S, 1'h1, etm_pkg::ADDR_S_FETCH_HI, 32'hdead_beef, 1'h1, 1'h0, 32'h0);
        add(M, M, 1'h0, etm_pkg::ADDR_M_LOAD_HI, 32'h0, 1'h0, 1'h0, 32'h0);
        add(M, M, 1'h0, etm_pkg::ADDR_M_LOAD_LO, 32'h0, 1'h0, 1'h0, 32'h1111_1111);
        repeat (2) @(negedge clock);
        check("reset_rsp", rsp_reg, '0);
        rst_n = 1'h1;
        @(negedge clock);
        // back-to-back requests, one per cycle
        foreach (rows[i]) begin
            core.access(rows[i].prv, rows[i].eff, rows[i].wr, rows[i].addr, rows[i].wd, rsp);
            if (!rows[i].ill) check("hit", rsp.hit, rows[i].addr != 12'h7c3);
            check("illegal", rsp.illegal, rows[i].ill);
            check("flush", rsp.flush, rows[i].fl);
            check("rdata", rsp.rdata, rows[i].rd);
            check("off_rsp", off_rsp_reg, '0);
            if (rows[i].wr && !rows[i].ill) sh[sidx(rows[i].addr)] = rows[i].wd;
        end
        tweaks(M, M, 1'h0);
        tweaks(M, M, 1'h1);
        tweaks(U, U, 1'h0);
        tweaks(S, S, 1'h1);
        tweaks(M, U, 1'h1);
        // reset in mid-run clears every modifier
        rst_n = 1'h0;
        @(negedge clock);
        check("reset_itw", itw, 64'h0);
        check("reset_dtw", dtw, 64'h0);
        rst_n = 1'h1;
        foreach (sh[i]) sh[i] = 32'h0;
        core.access(M, M, 1'h0, etm_pkg::ADDR_M_LOAD_LO, 32'h0, rsp);
        check("reset_rdata", rsp.rdata, 32'h0);
        tweaks(U, U, 1'h1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
